// ### src/flash_host_map.vh
// Constants for the flash host controller
// Notes on behaviour
// - After timeout flag rises, host writes reset; device returns to array read.
// - Two unlocks plus autoselect command enter autoselect; reads repeat freely.
// - Autoselect holds until the host writes reset.
// - Program is two unlocks, set-up, then address and data.
// - Hardware reset kills programming; host restarts the sequence. The model only blocks writes in reset; programs still finish.
// - Write cycle only with chip and write strobe low, output enable high.
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH
`define UNLOCK1_ADDR 18'h0_0555
`define UNLOCK2_ADDR 18'h0_02AA
`define UNLOCK1_DATA 16'h0000_00AA
`define UNLOCK2_DATA 16'h0000_0055
`define CMD_RESET 16'h0000_00F0
`define CMD_AUTOSEL 16'h0000_0090
`define CMD_PROGRAM 16'h0000_00A0
`define POLL_BIT 7
`define TOUT_BIT 5
`define OP_RESET 2'h0
`define OP_AUTOSEL 2'h1
`define OP_PROGRAM 2'h2
`define OP_READ 2'h3
// Phase lengths in system cycles, each at least one 100 ns cycle
`define T_SETUP 4'h1
`define T_PULSE 4'h1
`define T_READ 4'h1
`endif

// ### src/flash_host.v
// Host controller driving the flash command interface
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host
(
    input wire SYS_CLK_I,
    input wire ARST_N_I,
    input wire CMD_VALID_I,
    input wire [1:0] CMD_OP_I,
    input wire [17:0] CMD_ADDR_I,
    input wire [15:0] CMD_DATA_I,
    output reg CMD_READY_O,
    output reg DONE_O,
    output reg ERROR_O,
    output reg [15:0] RDATA_O,
    input wire [15:0] FL_DQ_I,
    input wire FL_READY_BUSY_OUT_I,
    output reg [17:0] FL_ADDR_O,
    output reg [15:0] FL_DQ_O,
    output reg FL_DQ_OE_O,
    output reg FL_CE_N_O,
    output reg FL_WE_N_O,
    output reg FL_OE_N_O,
    output reg FL_RESET_N_O
);
    localparam S_IDLE = 7'h01;
    localparam S_SETUP = 7'h02;
    localparam S_WPULSE = 7'h04;
    localparam S_WHOLD = 7'h08;
    localparam S_READ = 7'h10;
    localparam S_POLL = 7'h20;
    localparam S_DONE = 7'h40;

    reg [6:0] state_r;
    reg [6:0] state_nxt;
    reg [3:0] cnt_r;
    reg [3:0] cnt_nxt;
    reg [2:0] step_r;
    reg [2:0] step_nxt;
    reg [1:0] op_r;
    reg [17:0] addr_r;
    reg [15:0] data_r;
    reg [15:0] dq_s1_r;
    reg [15:0] dq_s2_r;
    reg ry_s1_r;
    reg ry_s2_r;
    reg [2:0] nsteps;
    reg [17:0] wa;
    reg [15:0] wd;

    // Pin inputs pass two flip-flops before use
    always @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
            ry_s1_r <= 1'b0;
            ry_s2_r <= 1'b0;
        end
        else
        begin
            dq_s1_r <= FL_DQ_I;
            dq_s2_r <= dq_s1_r;
            ry_s1_r <= FL_READY_BUSY_OUT_I;
            ry_s2_r <= ry_s1_r;
        end
    end

    // Cycle count and address/data of each write step
    always @*
    begin
        nsteps = 3'd1;
        wa = `UNLOCK1_ADDR;
        wd = `UNLOCK1_DATA;
        case (op_r)
            `OP_RESET: nsteps = 3'd1;
            `OP_AUTOSEL: nsteps = 3'd3;
            `OP_PROGRAM: nsteps = 3'd4;
            default: nsteps = 3'd0;
        endcase
        if (op_r == `OP_RESET)
        begin
            wa = addr_r;
            wd = `CMD_RESET;
        end
        else
        begin
            case (step_r)
                3'd0:
                begin
                    wa = `UNLOCK1_ADDR;
                    wd = `UNLOCK1_DATA;
                end
                3'd1:
                begin
                    wa = `UNLOCK2_ADDR;
                    wd = `UNLOCK2_DATA;
                end
                3'd2:
                begin
                    wa = `UNLOCK1_ADDR;
                    wd = (op_r == `OP_PROGRAM) ? `CMD_PROGRAM : `CMD_AUTOSEL;
                end
                default:
                begin
                    wa = addr_r;
                    wd = data_r;
                end
            endcase
        end
    end

    always @*
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        step_nxt = step_r;
        case (state_r)
            S_IDLE:
            begin
                step_nxt = 3'd0;
                // Read waits a cycle more so the synchroniser holds the new word
                cnt_nxt = (CMD_OP_I == `OP_READ) ? `T_READ + 4'h1 : `T_SETUP;
                if (CMD_VALID_I)
                    state_nxt = (CMD_OP_I == `OP_READ) ? S_READ : S_SETUP;
            end
            S_SETUP:
            begin
                // Address and data settle with strobe high; device latches address
                // when write strobe falls after chip select
                if (cnt_r == 4'h0)
                begin
                    state_nxt = S_WPULSE;
                    cnt_nxt = `T_PULSE;
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            S_WPULSE:
            begin
                if (cnt_r == 4'h0)
                begin
                    state_nxt = S_WHOLD;
                    cnt_nxt = `T_SETUP;
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            S_WHOLD:
            begin
                if (cnt_r == 4'h0)
                begin
                    step_nxt = step_r + 3'd1;
                    cnt_nxt = `T_SETUP;
                    if (step_r + 3'd1 == nsteps)
                    begin
                        // First poll must not judge the write data still in the synchroniser
                        state_nxt = (op_r == `OP_PROGRAM) ? S_POLL : S_DONE;
                        cnt_nxt = `T_READ + 4'h1;
                    end
                    else
                        state_nxt = S_SETUP;
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            S_READ:
            begin
                // Sample only after the synchroniser has caught settled data
                if (cnt_r == 4'h0)
                    state_nxt = S_DONE;
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            S_POLL:
            begin
                // Host writes nothing while programming; it only polls
                if (cnt_r == 4'h0)
                begin
                    if (ry_s2_r && dq_s2_r[`POLL_BIT] == data_r[`POLL_BIT])
                        state_nxt = S_DONE;
                    else if (dq_s2_r[`TOUT_BIT])
                        state_nxt = S_DONE;
                    cnt_nxt = `T_READ + 4'h2;
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            S_DONE:
                state_nxt = S_IDLE;
            default:
                state_nxt = S_IDLE;
        endcase
    end

    always @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_r <= S_IDLE;
            cnt_r <= 4'h0;
            step_r <= 3'd0;
            op_r <= `OP_RESET;
            addr_r <= 18'h0_0000;
            data_r <= 16'h0000;
            CMD_READY_O <= 1'b0;
            DONE_O <= 1'b0;
            ERROR_O <= 1'b0;
            RDATA_O <= 16'h0000;
            FL_ADDR_O <= 18'h0_0000;
            FL_DQ_O <= 16'h0000;
            FL_DQ_OE_O <= 1'b0;
            FL_CE_N_O <= 1'b1;
            FL_WE_N_O <= 1'b1;
            FL_OE_N_O <= 1'b1;
            FL_RESET_N_O <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            step_r <= step_nxt;
            FL_RESET_N_O <= 1'b1;
            DONE_O <= 1'b0;
            CMD_READY_O <= (state_nxt == S_IDLE);
            if (state_r == S_IDLE && CMD_VALID_I)
            begin
                op_r <= CMD_OP_I;
                addr_r <= CMD_ADDR_I;
                data_r <= CMD_DATA_I;
                ERROR_O <= 1'b0;
            end
            if (state_r == S_POLL && cnt_r == 4'h0 && state_nxt == S_DONE)
                ERROR_O <= !(ry_s2_r && dq_s2_r[`POLL_BIT] == data_r[`POLL_BIT]);
            if (state_r == S_READ && cnt_r == 4'h0)
                RDATA_O <= dq_s2_r;
            if (state_nxt == S_DONE)
                DONE_O <= 1'b1;
            // Output enable kept high during any write so no write is inhibited
            FL_OE_N_O <= !(state_nxt == S_READ || state_nxt == S_POLL);
            FL_CE_N_O <= (state_nxt == S_IDLE || state_nxt == S_DONE);
            FL_WE_N_O <= (state_nxt != S_WPULSE);
            FL_DQ_OE_O <= (state_nxt == S_SETUP || state_nxt == S_WPULSE ||
                           state_nxt == S_WHOLD);
            if (state_nxt == S_SETUP)
            begin
                FL_ADDR_O <= (state_r == S_IDLE) ? ((CMD_OP_I == `OP_RESET) ?
                             CMD_ADDR_I : `UNLOCK1_ADDR) : wa;
                FL_DQ_O <= (state_r == S_IDLE) ? ((CMD_OP_I == `OP_RESET) ?
                           `CMD_RESET : `UNLOCK1_DATA) : wd;
            end
            else if (state_nxt == S_READ || state_nxt == S_POLL)
                FL_ADDR_O <= (state_r == S_IDLE) ? CMD_ADDR_I : addr_r;
        end
    end
endmodule

// ### verification/flash_host_chk.sv
// Port checker for the flash host controller
`timescale 1ns/1ps
module flash_host_chk
(
    input logic SYS_CLK_I, ARST_N_I, CMD_VALID_I, CMD_READY_O, DONE_O,
    input logic [17:0] FL_ADDR_O,
    input logic [15:0] FL_DQ_O,
    input logic FL_DQ_OE_O, FL_CE_N_O, FL_WE_N_O, FL_OE_N_O, FL_RESET_N_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    chk_we_gated: assert property (!FL_WE_N_O |-> !FL_CE_N_O && FL_OE_N_O)
        else $error("write strobe outside select");
    chk_oe_no_drive: assert property (!FL_OE_N_O |-> !FL_DQ_OE_O)
        else $error("bus fight on data");
    chk_addr_held: assert property (!FL_WE_N_O |-> $stable(FL_ADDR_O))
        else $error("address moved in write");
    chk_data_held: assert property ($rose(FL_WE_N_O) |-> FL_DQ_OE_O && $stable(FL_DQ_O))
        else $error("data moved at strobe rise");
    chk_we_width: assert property ($fell(FL_WE_N_O) |=> !FL_WE_N_O ##1 FL_WE_N_O)
        else $error("write pulse length");
    chk_done_pulse: assert property (DONE_O |=> !DONE_O)
        else $error("done longer than a cycle");
    chk_take_start: assert property (CMD_VALID_I && CMD_READY_O |=>
        !CMD_READY_O ##[0:1] !FL_CE_N_O) else $error("request not started");
    chk_rst_pin: assert property (CMD_READY_O |-> FL_RESET_N_O && FL_CE_N_O)
        else $error("idle with device held");
    cover property ($rose(FL_WE_N_O));
    cover property (!FL_OE_N_O);
    cover property (DONE_O);
endmodule
bind flash_host flash_host_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I),
    .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O), .DONE_O(DONE_O),
    .FL_ADDR_O(FL_ADDR_O), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O),
    .FL_CE_N_O(FL_CE_N_O), .FL_WE_N_O(FL_WE_N_O), .FL_OE_N_O(FL_OE_N_O),
    .FL_RESET_N_O(FL_RESET_N_O));

// ### verification/flash_model.sv
// Behavioural flash device facing the host controller
`timescale 1ns/1ps
// Identity codes are arbitrary values
module flash_model #(parameter MAKER = 16'h00C1, DEV = 16'h00C2, CONT = 16'h00C3)
(
    input wire [17:0] a_i,
    input wire [15:0] d_i,
    input wire ce_n_i, we_n_i, oe_n_i, rst_n_i,
    output reg [15:0] q_o,
    output reg ry_o
);
    reg [15:0] mem [0:15];
    reg [15:0] pd;
    reg [17:0] la;
    reg [2:0] st;
    reg armed;
    // Sector held protected; no high voltage ever reaches the reset pin here
    localparam [5:0] LOCKED = 6'h3F;
    integer i;
    initial
    begin
        q_o = 16'hFFFF;
        ry_o = 1'b1;
        st = 3'h0;
        armed = 1'b0;
        pd = 16'h0000;
        for (i = 0; i < 16; i = i + 1)
            mem[i] = 16'hFFFF;
    end
    always @(negedge we_n_i) if (!ce_n_i) la = a_i;
    // Blocking delay while busy also ignores any write made meanwhile
    // Strobes low since power-up must not count as a write
    always @(posedge ce_n_i or negedge oe_n_i) armed = 1'b1;
    always @(posedge we_n_i) if (armed && !ce_n_i && oe_n_i && rst_n_i)
    begin
        if (d_i[7:0] == 8'hF0 && st != 3'h4)
            st = 3'h0;
        else case (st)
            3'h0: st = (la[10:0] == 11'h555 && d_i[7:0] == 8'hAA) ? 3'h1 : 3'h0;
            3'h1: st = (la[10:0] == 11'h2AA && d_i[7:0] == 8'h55) ? 3'h2 : 3'h0;
            3'h2: st = d_i[7:0] == 8'h90 ? 3'h3 : d_i[7:0] == 8'hA0 ? 3'h4 : 3'h0;
            3'h4:
            if (la[17:12] == LOCKED)
                st = 3'h0;
            else
            begin
                pd = d_i;
                mem[la[3:0]] = mem[la[3:0]] & d_i;
                st = 3'h5;
                ry_o = 1'b0;
                #2000;
                ry_o = 1'b1;
                st = |(pd & ~mem[la[3:0]]) ? 3'h6 : 3'h0;
            end
            default: st = st;
        endcase
    end
    // Released bus shows the inverse so stale data cannot pass
    always @(ce_n_i, oe_n_i, a_i, st)
        #1 q_o = (ce_n_i | oe_n_i) ? ~q_o : st[2] ? {8'h00, ~pd[7], 1'b0, st[1], 5'h00}
            : st != 3'h3 ? mem[a_i[3:0]] : a_i[7:0] == 8'h00 ? MAKER
            : a_i[7:0] == 8'h01 ? DEV : a_i[7:0] == 8'h03 ? CONT
            : {15'h0000, a_i[7:0] == 8'h02 && a_i[17:12] == LOCKED};
endmodule

// ### verification/flash_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_host_tb;
    reg clk, rst_n, vld;
    reg [1:0] op;
    reg [17:0] adr;
    reg [15:0] dat;
    wire rdy, done, err, foe, ce, we, oe, frst, ry;
    wire [15:0] rdata, fdq, mq;
    wire [17:0] fa;
    wire [15:0] dq = foe ? fdq : mq;
    integer fails = 0, checks_done = 0;
    flash_host DUT (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .CMD_VALID_I(vld), .CMD_OP_I(op),
        .CMD_ADDR_I(adr), .CMD_DATA_I(dat), .CMD_READY_O(rdy), .DONE_O(done),
        .ERROR_O(err), .RDATA_O(rdata), .FL_DQ_I(dq), .FL_READY_BUSY_OUT_I(ry), .FL_ADDR_O(fa),
        .FL_DQ_O(fdq), .FL_DQ_OE_O(foe), .FL_CE_N_O(ce), .FL_WE_N_O(we), .FL_OE_N_O(oe),
        .FL_RESET_N_O(frst));
    flash_model u_dev (.a_i(fa), .d_i(fdq), .ce_n_i(ce), .we_n_i(we), .oe_n_i(oe),
        .rst_n_i(frst), .q_o(mq), .ry_o(ry));
    always #50 clk = ~clk;
    task tally_and_finish;
    begin
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task cmp(input [15:0] got, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // Done is awaited under a bound; a missing done counts as a mismatch
    task run(input [1:0] o, input [17:0] a, input [15:0] d);
    begin
        vld <= 1'b1;
        op <= o;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        vld <= 1'b0;
        repeat (3000) if (done !== 1'b1) @(posedge clk);
        cmp({15'h0000, done}, 16'h0001);
        @(posedge clk);
    end
    endtask
    task t_power;
    begin
        run(2'h3, 18'h0_0007, 16'h0000);
        cmp(rdata, 16'hFFFF);
    end
    endtask
    task t_ids;
    begin
        run(2'h1, 18'h0_0000, 16'h0000);
        run(2'h3, 18'h3_FF00, 16'h0000);
        cmp(rdata, 16'h00C1);
        run(2'h3, 18'h1_0101, 16'h0000);
        cmp(rdata, 16'h00C2);
        run(2'h3, 18'h0_0003, 16'h0000);
        cmp(rdata, 16'h00C3);
        run(2'h3, 18'h2_0002, 16'h0000);
        cmp(rdata, 16'h0000);
        run(2'h3, 18'h3_F002, 16'h0000);
        cmp(rdata, 16'h0001);
        run(2'h3, 18'h0_0000, 16'h0000);
        cmp(rdata, 16'h00C1);
        run(2'h0, 18'h2_1234, 16'h0000);
        run(2'h3, 18'h0_0000, 16'h0000);
        cmp(rdata, 16'hFFFF);
    end
    endtask
    task t_prog;
    begin
        run(2'h2, 18'h0_0005, 16'h1234);
        cmp({15'h0000, err}, 16'h0000);
        run(2'h3, 18'h0_0005, 16'h0000);
        cmp(rdata, 16'h1234);
        run(2'h2, 18'h3_000C, 16'hA5A5);
        run(2'h3, 18'h0_000C, 16'h0000);
        cmp(rdata, 16'hA5A5);
        run(2'h2, 18'h0_0005, 16'hFFFF);
        cmp({15'h0000, err}, 16'h0001);
        run(2'h0, 18'h0_0000, 16'h0000);
        cmp({15'h0000, err}, 16'h0000);
        run(2'h3, 18'h0_0005, 16'h0000);
        cmp(rdata, 16'h1234);
        run(2'h2, 18'h3_F00E, 16'h0000);
        cmp({15'h0000, err}, 16'h0001);
        run(2'h3, 18'h3_F00E, 16'h0000);
        cmp(rdata, 16'hFFFF);
    end
    endtask
    initial
    begin
        #2000000;
        fails = fails + 1;
        tally_and_finish;
    end
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        vld = 1'b0;
        op = 2'h0;
        adr = 18'h0_0000;
        dat = 16'h0000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_power;
        t_ids;
        t_prog;
        tally_and_finish;
    end
endmodule
